// file: regch_pkg.sv
// Shared constants for the two-channel regulator register file.
// Assumes byte-wide register access from a serial slave front end.
package regch_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_MAX_LIMIT = 8'h02;
  localparam logic [7:0] OFS_TRK_CFG = 8'h03;
  localparam logic [7:0] OFS_FAULT = 8'h04;
  localparam logic [7:0] OFS_CH_CFG = 8'h05;
  localparam logic [7:0] OFS_SLEW = 8'h06;
  localparam logic [7:0] OFS_TARGET = 8'h07;
  localparam logic [7:0] OFS_TRK_VOLT = 8'h2b;
  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int CODE_W = 7;
  localparam int TRK_EN_BIT = 7;
  localparam int STEP_SEL_BIT = 7;
  localparam int FLT_TRK_BIT = 6;
  localparam int FLT_VLIM_BIT = 1;
  localparam int SLEW_W = 4;
  localparam int TVOLT_W = 6;
  localparam logic [7:0] CH_CFG_MASK = 8'h8f;
  localparam logic [7:0] TRK_CFG_MASK = 8'h83;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TRK_CFG = 8'h02;
  localparam logic [7:0] RST_FAULT = 8'h00;
  localparam logic [7:0] RST_TRK_VOLT = 8'h00;
  // Identification values: arbitrary, not a real part code
  localparam logic [7:0] IDENT_CH1 = 8'h51;
  localparam logic [7:0] IDENT_CH2 = 8'h61;
  // ----------------------------------------------------------------
  // Tracking partner addresses and step weights
  // ----------------------------------------------------------------
  localparam logic [6:0] PARTNER_ADDR0 = 7'h38;
  localparam logic [6:0] PARTNER_ADDR1 = 7'h3c;
  localparam logic [6:0] PARTNER_ADDR2 = 7'h78;
  localparam logic [6:0] PARTNER_ADDR3 = 7'h7c;
  localparam logic [13:0] STEP_UV_FINE = 14'h2710;   // 10 mV in uV
  localparam logic [13:0] STEP_UV_COARSE = 14'h30d4; // 12.5 mV in uV
  // ----------------------------------------------------------------
  // Channel slave addresses: upper six bits, low bit from strap
  // ----------------------------------------------------------------
  localparam logic [5:0] SLAVE_HI_CH1 = 6'h1c;
  localparam logic [5:0] SLAVE_HI_CH2 = 6'h1d;
endpackage

// file: chan_bus_if.sv
// Register access path from the front decoder to one channel copy.
// Assumes a single mclk domain.
`timescale 1ns/1ps
interface chan_bus_if;
  logic sel;
  logic wr;
  logic load;
  logic [7:0] reg_addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport regs (input sel, input wr, input load, input reg_addr, input wdata, output rdata);
  modport ctrl (output sel, output wr, output load, output reg_addr, output wdata, input rdata);
endinterface

// file: channel_regs.sv
// One channel's register set with its derived control outputs.
// Assumes access strobes arrive already decoded for this channel.
`timescale 1ns/1ps
module channel_regs #(
  parameter logic [7:0] IDENT = 8'h00
) (
  input wire logic mclk,
  input wire logic rst_n,
  chan_bus_if.regs bus,
  input wire logic [6:0] otp_max,
  input wire logic [7:0] otp_cfg,
  input wire logic [3:0] otp_slew,
  input wire logic [6:0] otp_target,
  output logic [6:0] applied_code,
  output logic tracking_active,
  output logic [6:0] partner_addr,
  output logic [13:0] step_uv,
  output logic [3:0] slew_code,
  output logic [5:0] track_code
);
  typedef struct packed {
    logic [6:0] max_code;
    logic [7:0] trk_cfg;
    logic [7:0] ch_cfg;
    logic [3:0] slew;
    logic [6:0] target;
    logic [5:0] tvolt;
    logic [6:0] applied;
    logic trk_act;
    logic [6:0] partner;
    logic [13:0] step;
  } chan_state_t;

  chan_state_t st_ff;
  chan_state_t nxt_st;
  logic over_limit;
  logic trk_err;
  logic [7:0] fault;

  // ----------------------------------------------------------------
  // Status and readback
  // ----------------------------------------------------------------
  assign over_limit = st_ff.target > st_ff.max_code;
  assign trk_err = st_ff.trk_cfg[regch_pkg::TRK_EN_BIT] & ~st_ff.ch_cfg[regch_pkg::STEP_SEL_BIT];

  // Live fault bits, others read zero
  always_comb begin
    fault = regch_pkg::RST_FAULT;
    fault[regch_pkg::FLT_TRK_BIT] = trk_err;
    fault[regch_pkg::FLT_VLIM_BIT] = over_limit;
  end

  // Read mux, unused bits and unmapped offsets read zero
  always_comb begin
    unique case (bus.reg_addr)
      regch_pkg::OFS_IDENT: bus.rdata = IDENT;
      regch_pkg::OFS_MAX_LIMIT: bus.rdata = {1'b0, st_ff.max_code};
      regch_pkg::OFS_TRK_CFG: bus.rdata = st_ff.trk_cfg;
      regch_pkg::OFS_FAULT: bus.rdata = fault;
      regch_pkg::OFS_CH_CFG: bus.rdata = st_ff.ch_cfg;
      regch_pkg::OFS_SLEW: bus.rdata = {4'h0, st_ff.slew};
      regch_pkg::OFS_TARGET: bus.rdata = {1'b0, st_ff.target};
      regch_pkg::OFS_TRK_VOLT: bus.rdata = {2'h0, st_ff.tvolt};
      default: bus.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state: writes, power-on load, derived outputs
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (bus.load) begin
      nxt_st.max_code = otp_max;
      nxt_st.ch_cfg = otp_cfg & regch_pkg::CH_CFG_MASK;
      nxt_st.slew = otp_slew;
      nxt_st.target = otp_target;
    end else if (bus.sel && bus.wr) begin
      unique case (bus.reg_addr)
        regch_pkg::OFS_MAX_LIMIT: nxt_st.max_code = bus.wdata[6:0];
        regch_pkg::OFS_TRK_CFG: nxt_st.trk_cfg = bus.wdata & regch_pkg::TRK_CFG_MASK;
        regch_pkg::OFS_CH_CFG: nxt_st.ch_cfg = bus.wdata & regch_pkg::CH_CFG_MASK;
        regch_pkg::OFS_SLEW: nxt_st.slew = bus.wdata[3:0];
        regch_pkg::OFS_TARGET: nxt_st.target = bus.wdata[6:0];
        regch_pkg::OFS_TRK_VOLT: nxt_st.tvolt = bus.wdata[5:0];
        default: nxt_st.slew = st_ff.slew;
      endcase
    end
    // Capped code and tracking controls, registered for clean outputs
    nxt_st.applied = over_limit ? st_ff.max_code : st_ff.target;
    nxt_st.trk_act = st_ff.trk_cfg[regch_pkg::TRK_EN_BIT] & st_ff.ch_cfg[regch_pkg::STEP_SEL_BIT];
    unique case (st_ff.trk_cfg[1:0])
      2'h0: nxt_st.partner = regch_pkg::PARTNER_ADDR0;
      2'h1: nxt_st.partner = regch_pkg::PARTNER_ADDR1;
      2'h2: nxt_st.partner = regch_pkg::PARTNER_ADDR2;
      2'h3: nxt_st.partner = regch_pkg::PARTNER_ADDR3;
    endcase
    nxt_st.step = st_ff.ch_cfg[regch_pkg::STEP_SEL_BIT] ? regch_pkg::STEP_UV_COARSE
                                                        : regch_pkg::STEP_UV_FINE;
  end

  // State register, constants under reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.trk_cfg <= regch_pkg::RST_TRK_CFG;
      st_ff.tvolt <= regch_pkg::RST_TRK_VOLT[5:0];
      st_ff.partner <= regch_pkg::PARTNER_ADDR0;
      st_ff.step <= regch_pkg::STEP_UV_FINE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign applied_code = st_ff.applied;
  assign tracking_active = st_ff.trk_act;
  assign partner_addr = st_ff.partner;
  assign step_uv = st_ff.step;
  assign slew_code = st_ff.slew;
  assign track_code = st_ff.tvolt;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cap;
    @(posedge mclk) disable iff (!rst_n)
    ($past(st_ff.target) > $past(st_ff.max_code)) |-> (applied_code == $past(st_ff.max_code));
  endproperty
  a_cap: assert property (p_cap) else $error("applied code not capped");

  property p_nocap;
    @(posedge mclk) disable iff (!rst_n)
    ($past(st_ff.target) <= $past(st_ff.max_code)) |-> (applied_code == $past(st_ff.target));
  endproperty
  a_nocap: assert property (p_nocap) else $error("applied code differs from target");

  property p_maxw;
    @(posedge mclk) disable iff (!rst_n)
    (bus.reg_addr == regch_pkg::OFS_MAX_LIMIT) |-> (bus.rdata[7] == 1'b0);
  endproperty
  a_maxw: assert property (p_maxw) else $error("limit bit 7 not zero");

  property p_trk;
    @(posedge mclk) disable iff (!rst_n)
    ##1 tracking_active == ($past(st_ff.trk_cfg[7]) && $past(st_ff.ch_cfg[7]));
  endproperty
  a_trk: assert property (p_trk) else $error("tracking state wrong");

  property p_partner;
    @(posedge mclk) disable iff (!rst_n)
    ($past(st_ff.trk_cfg[1:0]) == 2'h3) |-> (partner_addr == 7'h7c);
  endproperty
  a_partner: assert property (p_partner) else $error("partner address wrong");

  property p_step;
    @(posedge mclk) disable iff (!rst_n)
    $rose(st_ff.ch_cfg[7]) |=> (step_uv == 14'h30d4);
  endproperty
  a_step: assert property (p_step) else $error("step weight wrong");

  property p_tracking_config_error;
    @(posedge mclk) disable iff (!rst_n)
    (bus.reg_addr == regch_pkg::OFS_FAULT) |-> (bus.rdata[6] == (st_ff.trk_cfg[7] && !st_ff.ch_cfg[7]));
  endproperty
  a_tracking_config_error: assert property (p_tracking_config_error) else $error("tracking error bit wrong");
endmodule // channel_regs

// file: regulator_channel_register_file.sv
// Top of the two-channel register file: decodes slave address,
// routes byte accesses, loads one-time-programmable defaults.
// Assumes a serial front end delivers decoded byte requests on mclk.
`timescale 1ns/1ps
module regulator_channel_register_file (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic addr_strap,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [6:0] req_slave_addr,
  input wire logic [7:0] req_reg_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ack,
  output logic resp_valid,
  output logic [7:0] resp_rdata,
  input wire logic [1:0][6:0] otp_max,
  input wire logic [1:0][7:0] otp_cfg,
  input wire logic [1:0][3:0] otp_slew,
  input wire logic [1:0][6:0] otp_target,
  output logic [1:0][6:0] applied_code,
  output logic [1:0] tracking_active,
  output logic [1:0][6:0] partner_addr,
  output logic [1:0][13:0] step_uv,
  output logic [1:0][3:0] slew_code,
  output logic [1:0][5:0] track_code
);
  typedef struct packed {
    logic load_pend;
    logic valid;
    logic [7:0] rdata;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;
  logic [1:0] hit;
  logic [6:0] ch1_addr;
  logic [6:0] ch2_addr;

  chan_bus_if ch1_bus ();
  chan_bus_if ch2_bus ();

  // ----------------------------------------------------------------
  // Slave address decode
  // ----------------------------------------------------------------
  assign ch1_addr = {regch_pkg::SLAVE_HI_CH1, addr_strap};
  assign ch2_addr = {regch_pkg::SLAVE_HI_CH2, addr_strap};
  assign hit[0] = req_valid && (req_slave_addr == ch1_addr);
  assign hit[1] = req_valid && (req_slave_addr == ch2_addr);
  assign req_ack = |hit;

  // Per-channel strobes; load raised while reset is asserted and for the first cycle after release
  assign ch1_bus.sel = hit[0];
  assign ch1_bus.wr = req_write;
  assign ch1_bus.load = st_ff.load_pend;
  assign ch1_bus.reg_addr = req_reg_addr;
  assign ch1_bus.wdata = req_wdata;
  assign ch2_bus.sel = hit[1];
  assign ch2_bus.wr = req_write;
  assign ch2_bus.load = st_ff.load_pend;
  assign ch2_bus.reg_addr = req_reg_addr;
  assign ch2_bus.wdata = req_wdata;

  // ----------------------------------------------------------------
  // Channel copies
  // ----------------------------------------------------------------
  channel_regs #(.IDENT(regch_pkg::IDENT_CH1)) u_ch1 (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(ch1_bus.regs),
    .otp_max(otp_max[0]),
    .otp_cfg(otp_cfg[0]),
    .otp_slew(otp_slew[0]),
    .otp_target(otp_target[0]),
    .applied_code(applied_code[0]),
    .tracking_active(tracking_active[0]),
    .partner_addr(partner_addr[0]),
    .step_uv(step_uv[0]),
    .slew_code(slew_code[0]),
    .track_code(track_code[0])
  );

  channel_regs #(.IDENT(regch_pkg::IDENT_CH2)) u_ch2 (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(ch2_bus.regs),
    .otp_max(otp_max[1]),
    .otp_cfg(otp_cfg[1]),
    .otp_slew(otp_slew[1]),
    .otp_target(otp_target[1]),
    .applied_code(applied_code[1]),
    .tracking_active(tracking_active[1]),
    .partner_addr(partner_addr[1]),
    .step_uv(step_uv[1]),
    .slew_code(slew_code[1]),
    .track_code(track_code[1])
  );

  // ----------------------------------------------------------------
  // Read response and power-on load sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.load_pend = 1'b0;
    nxt_st.valid = req_ack && !req_write;
    if (hit[0] && !req_write) begin
      nxt_st.rdata = ch1_bus.rdata;
    end else if (hit[1] && !req_write) begin
      nxt_st.rdata = ch2_bus.rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.load_pend <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign resp_valid = st_ff.valid;
  assign resp_rdata = st_ff.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A write taken by one channel leaves every register of the other alone
  property p_onehit;
    @(posedge mclk) disable iff (!rst_n)
    (hit[0] && req_write && !st_ff.load_pend) |=>
      ($stable(u_ch2.st_ff.max_code) && $stable(u_ch2.st_ff.trk_cfg) && $stable(u_ch2.st_ff.ch_cfg)
       && $stable(u_ch2.st_ff.slew) && $stable(u_ch2.st_ff.target) && $stable(u_ch2.st_ff.tvolt));
  endproperty
  a_onehit: assert property (p_onehit) else $error("write reached both channels");

  property p_twohit;
    @(posedge mclk) disable iff (!rst_n)
    (hit[1] && req_write && !st_ff.load_pend) |=>
      ($stable(u_ch1.st_ff.max_code) && $stable(u_ch1.st_ff.trk_cfg) && $stable(u_ch1.st_ff.ch_cfg)
       && $stable(u_ch1.st_ff.slew) && $stable(u_ch1.st_ff.target) && $stable(u_ch1.st_ff.tvolt));
  endproperty
  a_twohit: assert property (p_twohit) else $error("channel 2 write reached channel 1");

  // The general call address is never acknowledged
  property p_nogencall;
    @(posedge mclk) disable iff (!rst_n)
    (req_slave_addr == 7'h00) |-> !req_ack;
  endproperty
  a_nogencall: assert property (p_nogencall) else $error("general call acknowledged");

  // Read answers come one cycle after the taking edge, from the chosen copy
  property p_resp_ch1;
    @(posedge mclk) disable iff (!rst_n)
    (hit[0] && !req_write) |=> (resp_valid && (resp_rdata == $past(ch1_bus.rdata)));
  endproperty
  a_resp_ch1: assert property (p_resp_ch1) else $error("channel 1 read answer wrong");

  property p_resp_ch2;
    @(posedge mclk) disable iff (!rst_n)
    (hit[1] && !req_write) |=> (resp_valid && (resp_rdata == $past(ch2_bus.rdata)));
  endproperty
  a_resp_ch2: assert property (p_resp_ch2) else $error("channel 2 read answer wrong");

  // No answer pulse and no data change without an acknowledged read
  property p_resp_idle;
    @(posedge mclk) disable iff (!rst_n)
    !(req_ack && !req_write) |=> !resp_valid;
  endproperty
  a_resp_idle: assert property (p_resp_idle) else $error("answer pulse without read");

  property p_resp_hold;
    @(posedge mclk) disable iff (!rst_n)
    !(req_ack && !req_write) |=> $stable(resp_rdata);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("read data changed without read");

  // Channel 2 answers with its own identification value
  property p_ident2;
    @(posedge mclk) disable iff (!rst_n)
    (hit[1] && !req_write && (req_reg_addr == regch_pkg::OFS_IDENT)) |=> (resp_rdata == regch_pkg::IDENT_CH2);
  endproperty
  a_ident2: assert property (p_ident2) else $error("channel 2 identification wrong");

  // Unmapped offsets read as zero
  property p_unmapped;
    @(posedge mclk) disable iff (!rst_n)
    (hit[0] && !req_write && (req_reg_addr == 8'h01)) |=> (resp_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset not zero");

  // The default load is a single cycle that copies the programmed values
  property p_load_once;
    @(posedge mclk) disable iff (!rst_n)
    st_ff.load_pend |=> !st_ff.load_pend;
  endproperty
  a_load_once: assert property (p_load_once) else $error("default load repeated");

  property p_otp_ch1;
    @(posedge mclk) disable iff (!rst_n)
    st_ff.load_pend |=> (u_ch1.st_ff.max_code == $past(otp_max[0])) && (u_ch1.st_ff.target == $past(otp_target[0]))
      && (u_ch1.st_ff.slew == $past(otp_slew[0]))
      && (u_ch1.st_ff.ch_cfg == ($past(otp_cfg[0]) & regch_pkg::CH_CFG_MASK));
  endproperty
  a_otp_ch1: assert property (p_otp_ch1) else $error("channel 1 defaults not loaded");

  property p_otp_ch2;
    @(posedge mclk) disable iff (!rst_n)
    st_ff.load_pend |=> (u_ch2.st_ff.max_code == $past(otp_max[1])) && (u_ch2.st_ff.target == $past(otp_target[1]))
      && (u_ch2.st_ff.slew == $past(otp_slew[1]))
      && (u_ch2.st_ff.ch_cfg == ($past(otp_cfg[1]) & regch_pkg::CH_CFG_MASK));
  endproperty
  a_otp_ch2: assert property (p_otp_ch2) else $error("channel 2 defaults not loaded");

  // Tracking configuration comes out of reset with its fixed value
  property p_tcfg_reset;
    @(posedge mclk)
    $rose(rst_n) && !req_valid |-> (u_ch1.st_ff.trk_cfg == 8'h02) && (u_ch2.st_ff.trk_cfg == 8'h02);
  endproperty
  a_tcfg_reset: assert property (p_tcfg_reset) else $error("tracking config reset value wrong");
endmodule // regulator_channel_register_file

// file: two_wire_master_model.sv
// Far-side model: serial bus master front end issuing single byte requests.
// Assumes the register file is clocked by mclk and acknowledges combinationally.
`timescale 1ns/1ps
module two_wire_master_model (
  input wire logic mclk,
  output logic req_valid,
  output logic req_write,
  output logic [6:0] req_slave_addr,
  output logic [7:0] req_reg_addr,
  output logic [7:0] req_wdata,
  input wire logic req_ack,
  input wire logic resp_valid,
  input wire logic [7:0] resp_rdata
);
  // ------------------------------------------------------------
  // Idle bus
  // ------------------------------------------------------------
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_slave_addr = 7'h55;
    req_reg_addr = 8'ha5;
    req_wdata = 8'h5a;
  end

  // One access: driven at falling edge, held over the taking edge
  task automatic access(input logic wr, input logic [6:0] sa, input logic [7:0] ofs,
                        input logic [7:0] wd, output logic ack, output logic [7:0] rd);
    @(negedge mclk);
    req_valid = 1'b1;
    req_write = wr;
    req_slave_addr = sa;
    req_reg_addr = ofs;
    req_wdata = wd;
    @(posedge mclk);
    ack = req_ack;
    @(negedge mclk);
    // Released qualifiers show the inverse, never a stale value
    req_valid = 1'b0;
    req_write = ~wr;
    req_slave_addr = ~sa;
    req_reg_addr = ~ofs;
    req_wdata = ~wd;
    rd = (resp_valid === 1'b1) ? resp_rdata : 8'hxx;
  endtask
endmodule // two_wire_master_model

// file: regulator_channel_register_file_tb.sv
// Self-checking bench for the two-channel regulator register file.
// Assumes the far-side master model drives all request inputs.
`timescale 1ns/1ps
module regulator_channel_register_file_tb;
  localparam logic [6:0] A1 = {regch_pkg::SLAVE_HI_CH1, 1'b1};
  localparam logic [6:0] A2 = {regch_pkg::SLAVE_HI_CH2, 1'b1};
  logic mclk, rst_n, req_valid, req_write, req_ack, resp_valid;
  logic [6:0] req_slave_addr;
  logic [7:0] req_reg_addr, req_wdata, resp_rdata;
  logic [1:0][6:0] otp_max, otp_target, applied_code, partner_addr;
  logic [1:0][7:0] otp_cfg;
  logic [1:0][3:0] otp_slew, slew_code;
  logic [1:0] tracking_active;
  logic [1:0][13:0] step_uv;
  logic [1:0][5:0] track_code;
  logic [6:0] paddr [4];
  int errors = 0;
  int samples_checked = 0;

  regulator_channel_register_file u_dut (.mclk(mclk), .rst_n(rst_n), .addr_strap(1'b1),
    .req_valid(req_valid), .req_write(req_write), .req_slave_addr(req_slave_addr),
    .req_reg_addr(req_reg_addr), .req_wdata(req_wdata), .req_ack(req_ack), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .otp_max(otp_max), .otp_cfg(otp_cfg), .otp_slew(otp_slew),
    .otp_target(otp_target), .applied_code(applied_code), .tracking_active(tracking_active),
    .partner_addr(partner_addr), .step_uv(step_uv), .slew_code(slew_code), .track_code(track_code));
  two_wire_master_model u_master (.mclk(mclk), .req_valid(req_valid), .req_write(req_write),
    .req_slave_addr(req_slave_addr), .req_reg_addr(req_reg_addr), .req_wdata(req_wdata),
    .req_ack(req_ack), .resp_valid(resp_valid), .resp_rdata(resp_rdata));

  // ------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (50000) @(posedge mclk);
    errors++;
    $display("wrong value run length expected done seen hang");
    end_of_test();
  end

  // ------------------------------------------------------------
  // Checking tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] sa, input logic [7:0] ofs, input logic [7:0] d);
    logic a;
    logic [7:0] r;
    u_master.access(1'b1, sa, ofs, d, a, r);
    chk("write ack", 16'h1, {15'h0, a});
  endtask
  task automatic rd(input logic [6:0] sa, input logic [7:0] ofs, input logic [7:0] exp);
    logic a;
    logic [7:0] r;
    u_master.access(1'b0, sa, ofs, 8'h00, a, r);
    chk("read ack", 16'h1, {15'h0, a});
    chk($sformatf("reg %h", ofs), {8'h0, exp}, {8'h0, r});
  endtask
  // Derived outputs follow one edge behind the registers
  task automatic settle();
    repeat (2) @(negedge mclk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic a;
    logic [7:0] r;
    paddr = '{regch_pkg::PARTNER_ADDR0, regch_pkg::PARTNER_ADDR1, regch_pkg::PARTNER_ADDR2,
              regch_pkg::PARTNER_ADDR3};
    rst_n = 1'b0;
    otp_max = {7'h70, 7'h60};
    otp_target = {7'h10, 7'h20};
    otp_cfg = {8'h00, 8'hf3};
    otp_slew = {4'ha, 4'h5};
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    // Power-on values, unused bits zero
    rd(A1, regch_pkg::OFS_IDENT, regch_pkg::IDENT_CH1);
    rd(A2, regch_pkg::OFS_IDENT, regch_pkg::IDENT_CH2);
    rd(A1, regch_pkg::OFS_MAX_LIMIT, 8'h60);
    rd(A1, regch_pkg::OFS_TRK_CFG, regch_pkg::RST_TRK_CFG);
    rd(A1, regch_pkg::OFS_FAULT, regch_pkg::RST_FAULT);
    rd(A1, regch_pkg::OFS_CH_CFG, 8'h83);
    rd(A1, regch_pkg::OFS_SLEW, 8'h05);
    rd(A1, regch_pkg::OFS_TARGET, 8'h20);
    rd(A1, regch_pkg::OFS_TRK_VOLT, regch_pkg::RST_TRK_VOLT);
    rd(A1, 8'h01, 8'h00);
    rd(A2, regch_pkg::OFS_TARGET, 8'h10);
    chk("applied ch2", 16'h10, {9'h0, applied_code[1]});
    chk("step ch1", {2'b0, regch_pkg::STEP_UV_COARSE}, {2'b0, step_uv[0]});
    chk("step ch2", {2'b0, regch_pkg::STEP_UV_FINE}, {2'b0, step_uv[1]});
    chk("slew ch2", 16'ha, {12'h0, slew_code[1]});
    chk("partner ch1", {9'h0, regch_pkg::PARTNER_ADDR2}, {9'h0, partner_addr[0]});
    $display("test defaults done");
    // Limit cap, equal boundary, read-only places
    wr(A1, regch_pkg::OFS_MAX_LIMIT, 8'hc0);
    rd(A1, regch_pkg::OFS_MAX_LIMIT, 8'h40);
    wr(A1, regch_pkg::OFS_TARGET, 8'h41);
    settle();
    chk("capped code", 16'h40, {9'h0, applied_code[0]});
    rd(A1, regch_pkg::OFS_FAULT, 8'h02);
    wr(A1, regch_pkg::OFS_TARGET, 8'h40);
    settle();
    chk("equal code", 16'h40, {9'h0, applied_code[0]});
    rd(A1, regch_pkg::OFS_FAULT, 8'h00);
    wr(A1, regch_pkg::OFS_FAULT, 8'hff);
    rd(A1, regch_pkg::OFS_FAULT, 8'h00);
    wr(A1, regch_pkg::OFS_IDENT, 8'h00);
    rd(A1, regch_pkg::OFS_IDENT, regch_pkg::IDENT_CH1);
    wr(A1, regch_pkg::OFS_SLEW, 8'hf7);
    rd(A1, regch_pkg::OFS_SLEW, 8'h07);
    settle();
    chk("slew ch1", 16'h7, {12'h0, slew_code[0]});
    $display("test limit done");
    // Every enable and step combination
    for (int i = 0; i < 4; i++) begin
      wr(A1, regch_pkg::OFS_CH_CFG, {i[0], 7'h00});
      wr(A1, regch_pkg::OFS_TRK_CFG, {i[1], 7'h01});
      settle();
      chk("tracking", {15'h0, i[1] & i[0]}, {15'h0, tracking_active[0]});
      chk("step", {2'b0, i[0] ? regch_pkg::STEP_UV_COARSE : regch_pkg::STEP_UV_FINE}, {2'b0, step_uv[0]});
      rd(A1, regch_pkg::OFS_FAULT, {1'b0, i[1] & ~i[0], 6'h00});
    end
    chk("tracking ch2", 16'h0, {15'h0, tracking_active[1]});
    $display("test tracking done");
    // Every partner select code
    for (int i = 0; i < 4; i++) begin
      wr(A1, regch_pkg::OFS_TRK_CFG, 8'h7c | 8'(i));
      settle();
      chk("partner", {9'h0, paddr[i]}, {9'h0, partner_addr[0]});
      rd(A1, regch_pkg::OFS_TRK_CFG, 8'(i));
    end
    $display("test partner done");
    // Channel separation and unmatched addresses
    wr(A2, regch_pkg::OFS_TARGET, 8'h05);
    wr(A1, regch_pkg::OFS_TRK_VOLT, 8'hff);
    settle();
    chk("applied ch2", 16'h05, {9'h0, applied_code[1]});
    chk("applied ch1", 16'h40, {9'h0, applied_code[0]});
    chk("track ch1", 16'h3f, {10'h0, track_code[0]});
    chk("track ch2", 16'h0, {10'h0, track_code[1]});
    u_master.access(1'b1, 7'h38, regch_pkg::OFS_TARGET, 8'h11, a, r);
    chk("strap miss ack", 16'h0, {15'h0, a});
    u_master.access(1'b1, 7'h00, regch_pkg::OFS_TARGET, 8'h11, a, r);
    chk("general call ack", 16'h0, {15'h0, a});
    rd(A1, regch_pkg::OFS_TARGET, 8'h40);
    $display("test channels done");
    // Mid-run reset reloads fixed values and programmed defaults
    otp_max[0] = 7'h30;
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    rd(A1, regch_pkg::OFS_MAX_LIMIT, 8'h30);
    rd(A1, regch_pkg::OFS_TRK_CFG, regch_pkg::RST_TRK_CFG);
    rd(A1, regch_pkg::OFS_TRK_VOLT, regch_pkg::RST_TRK_VOLT);
    rd(A2, regch_pkg::OFS_TARGET, 8'h10);
    chk("applied after reset", 16'h20, {9'h0, applied_code[0]});
    chk("partner ch1 after reset", {9'h0, regch_pkg::PARTNER_ADDR2}, {9'h0, partner_addr[0]});
    chk("partner ch2 after reset", {9'h0, regch_pkg::PARTNER_ADDR2}, {9'h0, partner_addr[1]});
    $display("test reset done");
    end_of_test();
  end
endmodule // regulator_channel_register_file_tb
